// *** core/tfmd_top.v ***
// common memory task file decoder with data port byte steering
// Functional notes
// - config index 0 selects memory mapping; other indexes turn decode off
// - 2KB memory window, data port FIFO-like
// - both enables: offset 0 is 16-bit
// - low-only bytes at 0: even then odd
// - high-only byte at 0: error/feature
// - offsets 8,9,D duplicate 0 and 1
// - repeated 8/0 or 8-9 step bytes
// - 9 then 8 gives odd then even
// - repeated word accesses step words
// - 400h-7FFh aliases offsets 8 and 9
// - word at 8: even low, odd high
// - decode A3-A0 when attr negated, A10 low
// - Eh altstatus/control, Fh drive address
`timescale 1ns/1ns
`default_nettype none
`include "tfmd_consts.vh"
module tfmd_top (
  input wire clk_in,
  input wire rst_n_in,
  input wire [10:0] addr_in,
  input wire attr_sel_n_in,
  input wire low_byte_enable_n_in,
  input wire high_byte_enable_n_in,
  input wire oe_n_in,
  input wire we_n_in,
  input wire [15:0] data_in,
  input wire [1:0] cfg_index_in,
  input wire [15:0] buf_rd_word_in,
  input wire [7:0] error_in,
  input wire [7:0] status_in,
  input wire [7:0] drive_addr_in,
  output reg [15:0] data_out,
  output reg [15:0] data_oe_out,
  output reg buf_rd_pop_out,
  output reg buf_wr_push_out,
  output reg [15:0] buf_wr_word_out,
  output reg [7:0] feature_out,
  output reg [7:0] sector_count_out,
  output reg [7:0] sector_number_out,
  output reg [7:0] cylinder_low_out,
  output reg [7:0] cylinder_high_out,
  output reg [7:0] card_head_out,
  output reg [7:0] command_out,
  output reg command_strobe_out,
  output reg [7:0] device_control_out
);
  // every host pin crosses two flops; it costs two cycles of latency
  // pin bundle: addr, attr, ce lo, ce hi, oe, we, data
  wire [31:0] pins_raw;
  wire [31:0] pins_s;
  assign pins_raw = {addr_in, attr_sel_n_in, low_byte_enable_n_in,
                     high_byte_enable_n_in, oe_n_in, we_n_in, data_in};
  tfmd_sync #(.WIDTH(32)) u_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .async_in(pins_raw),
    .sync_out(pins_s)
  );
  // synchronised pin views
  wire [10:0] a_s = pins_s[31:21];
  wire attr_n_s = pins_s[20];
  wire lo_n_s = pins_s[19];
  wire hi_n_s = pins_s[18];
  wire oe_n_s = pins_s[17];
  wire we_n_s = pins_s[16];
  wire [15:0] d_s = pins_s[15:0];

  // a strobe held low parks the machine in READ or WRITE, so one action
  // per assertion; the idle test still compares all three one-hot state bits
  // access states, one-hot
  localparam ST_IDLE = 3'b001;
  localparam ST_READ = 3'b010;
  localparam ST_WRITE = 3'b100;
  reg [2:0] state;
  reg [2:0] next_state;

  // attribute space belongs to another block; a low attribute select only
  // gates this decoder off
  // card enable seen this cycle; only memory mapping decodes here
  wire card_sel = !attr_n_s ? 1'b0 : (!lo_n_s || !hi_n_s);
  wire mem_cfg = (cfg_index_in == `TFMD_CFG_MEM);
  // oe and we low together is refused: neither a read nor a write
  wire rd_act = card_sel && mem_cfg && !oe_n_s && we_n_s;
  wire wr_act = card_sel && mem_cfg && !we_n_s && oe_n_s;

  // A10 high ignores A9-A1, so an auto-incrementing block move stays on
  // the data port
  // effective offset: the alias window folds onto 8/9, A9-A4 ignored
  reg [3:0] ofs;
  always @* begin
    if (a_s[`TFMD_A_ALIAS])
      ofs = a_s[0] ? `TFMD_OFS_DUPODD : `TFMD_OFS_DUPEVEN;
    else
      ofs = a_s[`TFMD_A_OFS_HI:0];
  end
  wire word_acc = !lo_n_s && !hi_n_s;
  wire hi_only = lo_n_s && !hi_n_s;
  // data ports: 0 and 8; odd-byte port 9
  wire is_data = (ofs == `TFMD_OFS_DATA) || (ofs == `TFMD_OFS_DUPEVEN);
  wire is_odd = (ofs == `TFMD_OFS_DUPODD);
  wire is_err = (ofs == `TFMD_OFS_ERRFEAT) || (ofs == `TFMD_OFS_DUPERR) ||
                ((ofs == `TFMD_OFS_DATA) && hi_only);

  // byte phase: low means next byte is the even one of the word
  // limitation: the phase is shared, so byte reads and byte writes must not
  // interleave inside one word
  reg odd_phase;
  reg odd_first; // odd byte already given through 9, even byte still due
  reg [15:0] rd_word; // current buffer word latched for byte reads
  reg rd_word_ok; // rd_word holds a live word
  reg [7:0] wr_even; // even byte waiting for its odd partner

  // the strobe must go high for one synced cycle before the next access
  // access state machine, one action per strobe assertion
  always @* begin
    case (state)
      ST_IDLE: begin
        if (rd_act)
          next_state = ST_READ;
        else if (wr_act)
          next_state = ST_WRITE;
        else
          next_state = ST_IDLE;
      end
      ST_READ: next_state = rd_act ? ST_READ : ST_IDLE;
      ST_WRITE: next_state = wr_act ? ST_WRITE : ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end
  wire start_rd = (state == ST_IDLE) && rd_act;
  wire start_wr = (state == ST_IDLE) && wr_act;

  // evaluated every cycle but only captured on the first cycle of a read
  // read lane value for the current decode
  reg [15:0] rd_val;
  reg [15:0] rd_en;
  // cur_word falls back to the live head when nothing is latched
  // word reads fetch straight from the buffer; byte reads use cur_word, the latch once a first byte is taken
  wire [15:0] cur_word = rd_word_ok ? rd_word : buf_rd_word_in;
  always @* begin
    rd_val = `TFMD_RST_WORD;
    rd_en = 16'h0000;
    if (word_acc && (is_data || is_odd)) begin
      rd_val = buf_rd_word_in;
      rd_en = 16'hFFFF;
    end else if (hi_only) begin
      // high lane only; byte at odd register address or port 0
      rd_en = 16'hFF00;
      if (is_err)
        rd_val = {error_in, 8'h00};
      else if (is_data || is_odd)
        rd_val = {cur_word[15:8], 8'h00};
      else
        rd_val = {status_in, 8'h00};
    end else begin
      rd_en = word_acc ? 16'hFFFF : 16'h00FF;
      case (ofs)
        `TFMD_OFS_DATA, `TFMD_OFS_DUPEVEN: begin
          // after 9 went first the even byte is still owed
          if (odd_phase && !odd_first)
            rd_val[7:0] = cur_word[15:8];
          else
            rd_val[7:0] = cur_word[7:0];
        end
        `TFMD_OFS_DUPODD:
          rd_val[7:0] = cur_word[15:8];
        `TFMD_OFS_ERRFEAT, `TFMD_OFS_DUPERR: rd_val[7:0] = error_in;
        `TFMD_OFS_SECCNT: rd_val[7:0] = sector_count_out;
        `TFMD_OFS_SECNUM: rd_val[7:0] = sector_number_out;
        `TFMD_OFS_CYLLO: rd_val[7:0] = cylinder_low_out;
        `TFMD_OFS_CYLHI: rd_val[7:0] = cylinder_high_out;
        `TFMD_OFS_CARDHEAD: rd_val[7:0] = card_head_out;
        `TFMD_OFS_STATCMD, `TFMD_OFS_ALTCTL: rd_val[7:0] = status_in;
        `TFMD_OFS_DRVADDR: rd_val[7:0] = drive_addr_in;
        default: rd_val[7:0] = 8'h00; // holes at A,B,C read zero
      endcase
    end
  end

  // every output is a flop; the pulses clear by default each cycle
  // main sequential process: bus answer, buffer strobes, task file
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      state <= ST_IDLE;
      data_out <= `TFMD_RST_WORD;
      data_oe_out <= 16'h0000;
      buf_rd_pop_out <= 1'b0;
      buf_wr_push_out <= 1'b0;
      buf_wr_word_out <= `TFMD_RST_WORD;
      feature_out <= `TFMD_RST_BYTE;
      sector_count_out <= `TFMD_RST_BYTE;
      sector_number_out <= `TFMD_RST_BYTE;
      cylinder_low_out <= `TFMD_RST_BYTE;
      cylinder_high_out <= `TFMD_RST_BYTE;
      card_head_out <= `TFMD_RST_BYTE;
      command_out <= `TFMD_RST_BYTE;
      command_strobe_out <= 1'b0;
      device_control_out <= `TFMD_RST_BYTE;
      odd_phase <= 1'b0;
      odd_first <= 1'b0;
      rd_word <= `TFMD_RST_WORD;
      rd_word_ok <= 1'b0;
      wr_even <= `TFMD_RST_BYTE;
    end else begin
      state <= next_state;
      buf_rd_pop_out <= 1'b0;
      buf_wr_push_out <= 1'b0;
      command_strobe_out <= 1'b0;
      // lanes are captured on the first cycle of a read and held, so a pop
      // or a phase step during the strobe never changes what the host sees
      if (start_rd) begin
        data_out <= rd_val;
        data_oe_out <= rd_en;
      end else if (!rd_act) begin
        data_out <= `TFMD_RST_WORD;
        data_oe_out <= 16'h0000;
      end
      // buffer is sequential only, each word consumed once
      // a word read pops at once; low-lane byte reads pop on the second half, a high-lane byte at 8 or 9 pops at once
      if (start_rd && (is_data || is_odd)) begin
        if (word_acc) begin
          buf_rd_pop_out <= 1'b1;
          odd_phase <= 1'b0;
          odd_first <= 1'b0;
          rd_word_ok <= 1'b0;
        end else if (!hi_only && is_data && !odd_phase) begin
          rd_word <= buf_rd_word_in; // hold word for the odd byte
          rd_word_ok <= 1'b1;
          odd_phase <= 1'b1;
          odd_first <= 1'b0;
        end else if (!hi_only) begin
          // second byte by 8/0 or by 9: word done; 9 first only latches
          if (is_odd && !odd_phase) begin
            // 9 first: latch, then 8 gives the even byte
            rd_word <= buf_rd_word_in;
            rd_word_ok <= 1'b1;
            odd_phase <= 1'b1;
            odd_first <= 1'b1;
          end else begin
            buf_rd_pop_out <= 1'b1;
            odd_phase <= 1'b0;
            odd_first <= 1'b0;
            rd_word_ok <= 1'b0;
          end
        end else if (!is_err) begin
          // high lane alone at 8 or 9 takes the odd byte and ends the word
          buf_rd_pop_out <= 1'b1;
          odd_phase <= 1'b0;
          odd_first <= 1'b0;
          rd_word_ok <= 1'b0;
        end
      end
      // writes mirror reads: a word, or the odd half, pushes a full word
      if (start_wr) begin
        odd_first <= 1'b0; // a write clears odd_first but never rd_word_ok; a latched rd_word stays live
        if (word_acc && (is_data || is_odd)) begin
          buf_wr_word_out <= d_s;
          buf_wr_push_out <= 1'b1;
          odd_phase <= 1'b0;
        end else if (hi_only && is_err) begin
          feature_out <= d_s[15:8];
        end else if (hi_only && (is_data || is_odd)) begin
          buf_wr_word_out <= {d_s[15:8], wr_even};
          buf_wr_push_out <= 1'b1;
          odd_phase <= 1'b0;
        end else if (!hi_only) begin
          case (ofs)
            `TFMD_OFS_DATA, `TFMD_OFS_DUPEVEN: begin
              if (!odd_phase) begin
                wr_even <= d_s[7:0];
                odd_phase <= 1'b1;
              end else begin
                buf_wr_word_out <= {d_s[7:0], wr_even};
                buf_wr_push_out <= 1'b1;
                odd_phase <= 1'b0;
              end
            end
            `TFMD_OFS_DUPODD: begin
              buf_wr_word_out <= {d_s[7:0], wr_even};
              buf_wr_push_out <= 1'b1;
              odd_phase <= 1'b0;
            end
            `TFMD_OFS_ERRFEAT, `TFMD_OFS_DUPERR: feature_out <= d_s[7:0];
            `TFMD_OFS_SECCNT: sector_count_out <= d_s[7:0];
            `TFMD_OFS_SECNUM: sector_number_out <= d_s[7:0];
            `TFMD_OFS_CYLLO: cylinder_low_out <= d_s[7:0];
            `TFMD_OFS_CYLHI: cylinder_high_out <= d_s[7:0];
            `TFMD_OFS_CARDHEAD: card_head_out <= d_s[7:0];
            // command write also pulses the strobe for one cycle
            `TFMD_OFS_STATCMD: begin
              command_out <= d_s[7:0];
              command_strobe_out <= 1'b1;
            end
            `TFMD_OFS_ALTCTL: device_control_out <= d_s[7:0];
            default: ; // Fh writes reserved, holes ignored
          endcase
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** core/tfmd_consts.vh ***
// constants for the task file memory decoder
`ifndef TFMD_CONSTS_VH
`define TFMD_CONSTS_VH
// configuration indexes
`define TFMD_CFG_MEM 2'h0
`define TFMD_CFG_IO16 2'h1
`define TFMD_CFG_PRI 2'h2
`define TFMD_CFG_SEC 2'h3
// register offsets
`define TFMD_OFS_DATA 4'h0
`define TFMD_OFS_ERRFEAT 4'h1
`define TFMD_OFS_SECCNT 4'h2
`define TFMD_OFS_SECNUM 4'h3
`define TFMD_OFS_CYLLO 4'h4
`define TFMD_OFS_CYLHI 4'h5
`define TFMD_OFS_CARDHEAD 4'h6
`define TFMD_OFS_STATCMD 4'h7
`define TFMD_OFS_DUPEVEN 4'h8
`define TFMD_OFS_DUPODD 4'h9
`define TFMD_OFS_DUPERR 4'hD
`define TFMD_OFS_ALTCTL 4'hE
`define TFMD_OFS_DRVADDR 4'hF
// address field positions
`define TFMD_A_ALIAS 10
`define TFMD_A_OFS_HI 3
// reset values
`define TFMD_RST_BYTE 8'h00
`define TFMD_RST_WORD 16'h0000
`define TFMD_RST_STATUS 8'h50
`define TFMD_RST_DRVADDR 8'hFF
// fastest legal cycle for advanced timing
`define TFMD_FAST_CYCLE_NS 250
`endif

// *** core/tfmd_sync.v ***
// two flip-flop synchroniser bank for host pins
`timescale 1ns/1ns
`default_nettype none
module tfmd_sync #(
  parameter WIDTH = 16
) (
  input wire clk_in,
  input wire rst_n_in,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] stage1; // first stage, read only by sync_out
  genvar i;
  // one pair of flops per bit
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge clk_in) begin
        if (!rst_n_in) begin
          stage1[i] <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          stage1[i] <= async_in[i];
          sync_out[i] <= stage1[i];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// *** bench/tfmd_checker.sv ***
// port assertions for the task file decoder
`timescale 1ns/1ns
`default_nettype none
module tfmd_checker (
  input wire clk_in,
  input wire rst_n_in,
  input wire [10:0] addr_in,
  input wire attr_sel_n_in,
  input wire low_byte_enable_n_in,
  input wire high_byte_enable_n_in,
  input wire oe_n_in,
  input wire we_n_in,
  input wire [1:0] cfg_index_in,
  input wire [7:0] error_in,
  input wire [15:0] data_out,
  input wire [15:0] data_oe_out,
  input wire buf_rd_pop_out,
  input wire buf_wr_push_out,
  input wire command_strobe_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // a decoded read in memory mapping
  wire rd_sel = attr_sel_n_in && we_n_in && cfg_index_in == 2'h0;
  wire lo_only = !low_byte_enable_n_in && high_byte_enable_n_in;
  wire hi_only = low_byte_enable_n_in && !high_byte_enable_n_in;
  a_pop_one_pulse: assert property (buf_rd_pop_out |=> !buf_rd_pop_out)
    else $error("pop longer than one cycle");
  a_push_one_pulse: assert property (buf_wr_push_out |=> !buf_wr_push_out)
    else $error("push longer than one cycle");
  a_cmd_one_pulse: assert property (command_strobe_out |=> !command_strobe_out)
    else $error("command strobe too long");
  a_idle_lanes_off: assert property (oe_n_in [*5] |-> data_oe_out == 16'h0000)
    else $error("lanes driven while idle");
  a_cfg_no_answer: assert property ((cfg_index_in != 2'h0) [*5] |->
    data_oe_out == 16'h0000 && !buf_rd_pop_out)
    else $error("answer outside memory mapping");
  a_lane_shape: assert property (data_oe_out != 16'h0000 |->
    data_oe_out inside {16'h00FF, 16'hFF00, 16'hFFFF})
    else $error("bad lane enable pattern");
  a_word_lanes: assert property ($fell(oe_n_in) && rd_sel && !low_byte_enable_n_in &&
    !high_byte_enable_n_in && addr_in == 11'h000 |-> ##[2:4] data_oe_out == 16'hFFFF)
    else $error("word read not on all lanes");
  a_err_high_lane: assert property ($fell(oe_n_in) && rd_sel && hi_only && addr_in == 11'h000
    |-> ##[2:4] data_oe_out == 16'hFF00 && data_out[15:8] == error_in)
    else $error("error byte not on high lane");
  a_alias_low_lane: assert property ($fell(oe_n_in) && rd_sel && lo_only && addr_in[10]
    |-> ##[2:4] data_oe_out == 16'h00FF)
    else $error("alias byte read off low lane");
  c_word_pop: cover property (buf_rd_pop_out);
  c_push: cover property (buf_wr_push_out);
  c_cmd: cover property (command_strobe_out);
endmodule
bind tfmd_top tfmd_checker u_tfmd_checker (.clk_in, .rst_n_in, .addr_in, .attr_sel_n_in,
  .low_byte_enable_n_in, .high_byte_enable_n_in, .oe_n_in, .we_n_in, .cfg_index_in,
  .error_in, .data_out, .data_oe_out, .buf_rd_pop_out, .buf_wr_push_out,
  .command_strobe_out);
`default_nettype wire

// *** bench/tfmd_host_model.sv ***
// host strobe bus model for memory cycles
`timescale 1ns/1ns
`default_nettype none
module tfmd_host_model (
  input wire logic clk_in,
  input wire logic [15:0] rd_data_in,
  output var logic [10:0] addr_out,
  output var logic attr_n_out,
  output var logic lo_n_out,
  output var logic hi_n_out,
  output var logic oe_n_out,
  output var logic we_n_out,
  output var logic [15:0] wr_data_out
);
  // one card, no cable, so short cycles are allowed
  initial begin
    addr_out = 11'h000;
    attr_n_out = 1'b1;
    {hi_n_out, lo_n_out, oe_n_out, we_n_out} = 4'hF;
    wr_data_out = 16'h0000;
  end
  // callers never repeat byte accesses at offset 9 alone
  task automatic cyc(input logic [10:0] a, input logic [1:0] en_n, input logic wr,
      input logic [15:0] d, output logic [15:0] q);
    @(posedge clk_in);
    addr_out <= a;
    {hi_n_out, lo_n_out} <= en_n;
    {oe_n_out, we_n_out} <= {wr, !wr};
    wr_data_out <= wr ? d : ~wr_data_out;
    repeat (4) @(posedge clk_in);
    q = rd_data_in;
    // released data lines flip so stale values never look valid
    {hi_n_out, lo_n_out, oe_n_out, we_n_out} <= 4'hF;
    wr_data_out <= ~wr_data_out;
    repeat (3) @(posedge clk_in);
  endtask
endmodule
`default_nettype wire

// *** bench/task_file_memory_decode_tb_top.sv ***
// self-checking bench for the task file decoder
`timescale 1ns/1ns
`default_nettype none
module task_file_memory_decode_tb_top;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [1:0] cfg = 2'h0;
  logic [15:0] bw = 16'hA05A;
  logic [15:0] ew = 16'hA05A;
  logic [15:0] pw = 16'h0000;
  logic [15:0] q;
  int error_cnt = 0;
  int n_tests = 0;
  int n_cmd = 0;
  wire [10:0] a;
  wire at_n, lo_n, hi_n, oe_n, we_n, pop, push, cstb;
  wire [15:0] wd, rd, wbw;
  wire [7:0] ft, r2, r3, r4, r5, r6, r7, dc;
  tfmd_host_model u_tfmd_host_model (.clk_in(clk_in), .rd_data_in(rd), .addr_out(a),
    .attr_n_out(at_n), .lo_n_out(lo_n), .hi_n_out(hi_n), .oe_n_out(oe_n),
    .we_n_out(we_n), .wr_data_out(wd));
  tfmd_top u_tfmd_top (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(a),
    .attr_sel_n_in(at_n), .low_byte_enable_n_in(lo_n), .high_byte_enable_n_in(hi_n),
    .oe_n_in(oe_n), .we_n_in(we_n), .data_in(wd), .cfg_index_in(cfg), .buf_rd_word_in(bw),
    .error_in(8'hE5), .status_in(8'h51), .drive_addr_in(8'hD7), .data_out(rd),
    .data_oe_out(), .buf_rd_pop_out(pop), .buf_wr_push_out(push), .buf_wr_word_out(wbw),
    .feature_out(ft), .sector_count_out(r2), .sector_number_out(r3), .cylinder_low_out(r4),
    .cylinder_high_out(r5), .card_head_out(r6), .command_out(r7),
    .command_strobe_out(cstb), .device_control_out(dc));
  always #5 clk_in = ~clk_in;
  // sector buffer head advances on each pop
  always @(posedge clk_in) if (pop) bw <= bw + 16'h1111;
  always @(posedge clk_in) if (push) pw <= wbw;
  always @(posedge clk_in) if (cstb) n_cmd <= n_cmd + 1;
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic t_words;
    u_tfmd_host_model.cyc(11'h000, 2'h0, 1'b0, 16'h0000, q);
    chk("word0", ew, q);
    ew += 16'h1111;
    u_tfmd_host_model.cyc(11'h009, 2'h0, 1'b0, 16'h0000, q);
    chk("word9", ew, q);
    ew += 16'h1111;
    @(posedge clk_in) cfg <= 2'h1;
    u_tfmd_host_model.cyc(11'h000, 2'h0, 1'b0, 16'h0000, q);
    chk("cfg1lanes", 16'h0000, q);
    @(posedge clk_in) cfg <= 2'h0;
    chk("cfg1pop", ew, bw);
  endtask
  task automatic t_bytes;
    logic [10:0] pa [4] = '{11'h000, 11'h008, 11'h009, 11'h402};
    logic [10:0] pb [4] = '{11'h000, 11'h009, 11'h008, 11'h403};
    for (int i = 0; i < 4; i++) begin
      u_tfmd_host_model.cyc(pa[i], 2'h2, 1'b0, 16'h0000, q);
      chk("byte1", {8'h00, i == 2 ? ew[15:8] : ew[7:0]}, {8'h00, q[7:0]});
      u_tfmd_host_model.cyc(pb[i], 2'h2, 1'b0, 16'h0000, q);
      chk("byte2", {8'h00, i == 2 ? ew[7:0] : ew[15:8]}, {8'h00, q[7:0]});
      ew += 16'h1111;
    end
    chk("pops", ew, bw);
  endtask
  task automatic t_high;
    u_tfmd_host_model.cyc(11'h000, 2'h1, 1'b0, 16'h0000, q);
    chk("err0", 16'hE500, {q[15:8], 8'h00});
    u_tfmd_host_model.cyc(11'h00D, 2'h1, 1'b0, 16'h0000, q);
    chk("errD", 16'hE500, {q[15:8], 8'h00});
    u_tfmd_host_model.cyc(11'h008, 2'h1, 1'b0, 16'h0000, q);
    chk("odd8", {ew[15:8], 8'h00}, {q[15:8], 8'h00});
    ew += 16'h1111;
    chk("hipop", ew, bw);
    u_tfmd_host_model.cyc(11'h00D, 2'h1, 1'b1, 16'h3C00, q);
    chk("featD", 16'h003C, {8'h00, ft});
  endtask
  task automatic t_regs;
    logic [7:0] rg [6];
    logic [10:0] ra [5] = '{11'h007, 11'h00E, 11'h00F, 11'h00A, 11'h002};
    logic [7:0] rv [5] = '{8'h51, 8'h51, 8'hD7, 8'h00, 8'h40};
    for (int i = 0; i < 6; i++)
      u_tfmd_host_model.cyc(11'h012 + 11'(i), 2'h2, 1'b1, 16'h0040 + 16'(i), q);
    u_tfmd_host_model.cyc(11'h00E, 2'h2, 1'b1, 16'h0066, q);
    u_tfmd_host_model.cyc(11'h00F, 2'h2, 1'b1, 16'h0077, q);
    rg = '{r2, r3, r4, r5, r6, r7};
    for (int i = 0; i < 6; i++) chk("reg", 16'h0040 + 16'(i), {8'h00, rg[i]});
    chk("dctl", 16'h0066, {8'h00, dc});
    chk("cmdstb", 16'h0001, 16'(n_cmd));
    for (int i = 0; i < 5; i++) begin
      u_tfmd_host_model.cyc(ra[i], 2'h2, 1'b0, 16'h0000, q);
      chk("rdreg", {8'h00, rv[i]}, {8'h00, q[7:0]});
    end
  endtask
  task automatic t_writes;
    u_tfmd_host_model.cyc(11'h008, 2'h0, 1'b1, 16'hBEEF, q);
    chk("wpush", 16'hBEEF, pw);
    u_tfmd_host_model.cyc(11'h000, 2'h2, 1'b1, 16'h0012, q);
    u_tfmd_host_model.cyc(11'h000, 2'h2, 1'b1, 16'h0034, q);
    chk("bpush", 16'h3412, pw);
  endtask
  initial begin
    repeat (20000) @(posedge clk_in);
    error_cnt++;
    give_verdict();
  end
  initial begin
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1'b1;
    chk("rstval", 16'h0000, {ft, r2});
    t_words();
    t_bytes();
    t_high();
    t_regs();
    t_writes();
    give_verdict();
  end
endmodule
`default_nettype wire
